/* File: core/scsb_defs.svh */
// Purpose: Shared constants of the serial channel shift buffer
// Assumes: Included by bare name
// Notes:   Timing counts are in clk_sys cycles (250 MHz)
`ifndef SCSB_DEFS_SVH
`define SCSB_DEFS_SVH
`define SCSB_ADDR_CH0   20'hFFF10
`define SCSB_ADDR_CH1   20'hFFF12
`define SCSB_BUF_RST    8'h00
`define SCSB_DLS_BIT    0
`define SCSB_LEN7       4'h7
`define SCSB_LEN8       4'h8
`define SCSB_CLK_NS     4
`define SCSB_BIT_NS     64
`define SCSB_SCK_HALF_NS 32
`define SCSB_BAUD_DIV   (`SCSB_BIT_NS / `SCSB_CLK_NS)
`define SCSB_SCK_HALF   (`SCSB_SCK_HALF_NS / `SCSB_CLK_NS)
`define SCSB_FIFO_DEPTH 16
`define SCSB_WORD_W     8
`endif

/* File: core/scsb_pkg.sv */
// Purpose: Types of the serial channel shift buffer
// Assumes: Constants live in scsb_defs.svh
// Notes:   None
package scsb_pkg;
    typedef enum logic [1:0] {T_IDLE, T_START, T_DATA, T_STOP} scsb_tx_st_t;
    typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} scsb_rx_st_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [19:0] addr;
        logic [7:0]  wdata;
    } scsb_cpu_req_t;
    typedef struct packed {
        logic       run;
        logic [7:0] op_low;
        logic       msb_first;
        logic       three_wire;
        logic       master;
    } scsb_ch_cfg_t;
endpackage

/* File: core/scsb_fifo.sv */
// Purpose: Transmit FIFO between channel 0 buffer and shift register
// Assumes: Single clock, synchronous clear
// Notes:   Output word read straight from the array
`timescale 1ns/1ps
module scsb_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         clr,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (clr) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: core/scsb_top.sv */
// Purpose: Data path of a two-channel serial unit (shift register and buffers)
// Assumes: CPU byte access on clk_sys; pins synchronised here
// Notes:   Channel 0 is 3-wire or async transmit, channel 1 async receive
`timescale 1ns/1ps
`include "scsb_defs.svh"
module scsb_top #(
    parameter int BAUD_DIV   = `SCSB_BAUD_DIV,
    parameter int SCK_HALF   = `SCSB_SCK_HALF,
    parameter int FIFO_DEPTH = `SCSB_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // CPU byte access
    input  scsb_pkg::scsb_cpu_req_t cpu_req,
    output logic [7:0]             cpu_rdata,
    output logic                   tx_space,
    // Unit and channel settings
    input  wire logic              serial_unit_clock_enable,
    input  scsb_pkg::scsb_ch_cfg_t cfg0,
    input  scsb_pkg::scsb_ch_cfg_t cfg1,
    // 3-wire pins
    input  wire logic              three_wire_clock_pin_i,
    output logic                   three_wire_clock_pin_o,
    output logic                   three_wire_clock_pin_oe,
    input  wire logic              three_wire_data_in_pin,
    output logic                   three_wire_data_out_pin,
    // Async pins
    input  wire logic              async_receive_pin,
    output logic                   async_transmit_pin
);
    import scsb_pkg::*;

    function automatic logic [3:0] wlen(input logic [7:0] op);
        wlen = op[`SCSB_DLS_BIT] ? `SCSB_LEN8 : `SCSB_LEN7;
    endfunction

    function automatic logic [7:0] fit(input logic [7:0] v, input logic [3:0] len);
        fit = (len == `SCSB_LEN8) ? v : {1'b0, v[6:0]};
    endfunction

    function automatic logic out_bit(input logic [7:0] v, input logic msb, input logic [3:0] len);
        out_bit = msb ? v[3'(len - 4'h1)] : v[0];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic msb, input logic b);
        shift_in = msb ? {v[6:0], b} : {b, v[7:1]};
    endfunction

    // LSB-first 7-bit words land in bits 7:1 and need one step down
    function automatic logic [7:0] rx_align(input logic [7:0] v, input logic msb, input logic [3:0] len);
        rx_align = fit((!msb && len == `SCSB_LEN7) ? {1'b0, v[7:1]} : v, len);
    endfunction

    logic              en;
    logic [2:0]        sck_sy_q;
    logic [1:0]        si_sy_q;
    logic [2:0]        rx_sy_q;
    logic              sck_rise;
    logic              sck_fall;
    logic              si_s;
    logic              rx_s;
    logic [7:0]        buf0_q;
    logic [7:0]        buf1_q;
    logic [7:0]        rdata_q;
    logic              wr0;
    logic              wr1;
    logic [3:0]        len0;
    logic [3:0]        len1;
    scsb_tx_st_t       st0_q;
    logic [7:0]        sh0_q;
    logic [7:0]        sh0_nx;
    logic [3:0]        cnt0_q;
    logic [15:0]       tmr0_q;
    logic              tick0;
    logic              sck_q;
    logic              so0_q;
    logic              txd_q;
    logic              rise0;
    logic              fall0;
    logic              done0;
    logic              f_valid;
    logic              f_pop;
    logic [7:0]        f_data;
    scsb_rx_st_t       st1_q;
    logic [7:0]        sh1_q;
    logic [3:0]        cnt1_q;
    logic [15:0]       tmr1_q;
    logic              done1;
    logic [7:0]        rx1_word;

    // Plain level from the same clock domain
    assign en   = serial_unit_clock_enable;
    assign len0 = wlen(cfg0.op_low);
    assign len1 = wlen(cfg1.op_low);

    // Pin synchronisers; stage 0 feeds stage 1 only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sck_sy_q <= 3'h7;
            si_sy_q  <= 2'h3;
            rx_sy_q  <= 3'h7;
        end else begin
            sck_sy_q <= {sck_sy_q[1:0], three_wire_clock_pin_i};
            si_sy_q  <= {si_sy_q[0], three_wire_data_in_pin};
            rx_sy_q  <= {rx_sy_q[1:0], async_receive_pin};
        end
    end
    assign si_s     = si_sy_q[1];
    assign rx_s     = rx_sy_q[1];
    assign sck_rise = sck_sy_q[1] && !sck_sy_q[2];
    assign sck_fall = !sck_sy_q[1] && sck_sy_q[2];

    // CPU writes, gated by clock supply and run flag
    assign wr0 = cpu_req.wr && cpu_req.addr == `SCSB_ADDR_CH0 && en && cfg0.run;
    assign wr1 = cpu_req.wr && cpu_req.addr == `SCSB_ADDR_CH1 && en && cfg1.run;

    // Buffer takes no room in the FIFO; a full FIFO drops the byte
    scsb_fifo #(
        .W     (`SCSB_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .clr       (!en),
        .in_valid  (wr0),
        .in_ready  (tx_space),
        .in_data   (fit(cpu_req.wdata, len0)),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    // Channel 0 engine: 3-wire full duplex or async transmit
    assign f_pop  = en && cfg0.run && st0_q == T_IDLE && f_valid;
    assign tick0  = tmr0_q == 16'((cfg0.three_wire ? SCK_HALF : BAUD_DIV) - 1);
    assign rise0  = st0_q == T_DATA && (cfg0.master ? (tick0 && !sck_q) : sck_rise);
    assign fall0  = st0_q == T_DATA && (cfg0.master ? (tick0 && sck_q) : sck_fall);
    assign sh0_nx = shift_in(sh0_q, cfg0.msb_first, si_s);
    assign done0  = cfg0.three_wire && rise0 && cnt0_q == len0 - 4'h1;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tmr0_q <= '0;
        end else if (!en || f_pop || tick0) begin
            tmr0_q <= '0;
        end else begin
            tmr0_q <= tmr0_q + 16'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st0_q  <= T_IDLE;
            sh0_q  <= '0;
            cnt0_q <= '0;
            sck_q  <= 1'b1;
            so0_q  <= 1'b1;
            txd_q  <= 1'b1;
        end else if (!en || !cfg0.run) begin
            st0_q  <= T_IDLE;
            cnt0_q <= '0;
            sck_q  <= 1'b1;
            so0_q  <= 1'b1;
            txd_q  <= 1'b1;
        end else begin
            unique case (st0_q)
                T_IDLE: begin
                    if (f_pop) begin
                        sh0_q  <= f_data;
                        cnt0_q <= '0;
                        if (cfg0.three_wire) begin
                            st0_q <= T_DATA;
                            so0_q <= out_bit(f_data, cfg0.msb_first, len0);
                        end else begin
                            st0_q <= T_START;
                            txd_q <= 1'b0;
                        end
                    end
                end
                T_START: begin
                    if (tick0) begin
                        st0_q <= T_DATA;
                        txd_q <= out_bit(sh0_q, cfg0.msb_first, len0);
                    end
                end
                T_DATA: begin
                    if (cfg0.three_wire) begin
                        if (cfg0.master && tick0) begin
                            sck_q <= !sck_q;
                        end
                        if (rise0) begin
                            sh0_q  <= sh0_nx;
                            cnt0_q <= cnt0_q + 4'h1;
                            if (done0) begin
                                st0_q <= T_IDLE;
                            end
                        end
                        if (fall0 && cnt0_q != '0) begin
                            so0_q <= out_bit(sh0_q, cfg0.msb_first, len0);
                        end
                    end else if (tick0) begin
                        sh0_q  <= shift_in(sh0_q, cfg0.msb_first, 1'b0);
                        cnt0_q <= cnt0_q + 4'h1;
                        if (cnt0_q == len0 - 4'h1) begin
                            st0_q <= T_STOP;
                            txd_q <= 1'b1;
                        end else begin
                            txd_q <= out_bit(shift_in(sh0_q, cfg0.msb_first, 1'b0), cfg0.msb_first, len0);
                        end
                    end
                end
                T_STOP: begin
                    if (tick0) begin
                        st0_q <= T_IDLE;
                    end
                end
            endcase
        end
    end

    // Channel 1 engine: async receive only
    assign rx1_word = rx_align(shift_in(sh1_q, cfg1.msb_first, rx_s), cfg1.msb_first, len1);
    assign done1    = st1_q == R_STOP && tmr1_q == 16'(BAUD_DIV - 1);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st1_q  <= R_IDLE;
            sh1_q  <= '0;
            cnt1_q <= '0;
            tmr1_q <= '0;
        end else if (!en || !cfg1.run) begin
            st1_q  <= R_IDLE;
            cnt1_q <= '0;
            tmr1_q <= '0;
        end else begin
            tmr1_q <= tmr1_q + 16'h1;
            unique case (st1_q)
                R_IDLE: begin
                    tmr1_q <= '0;
                    if (rx_sy_q[2] && !rx_s) begin
                        st1_q  <= R_START;
                        sh1_q  <= '0;
                        cnt1_q <= '0;
                    end
                end
                R_START: begin
                    // Mid-bit check rejects glitches shorter than half a bit
                    if (tmr1_q == 16'(BAUD_DIV / 2 - 1)) begin
                        tmr1_q <= '0;
                        st1_q  <= rx_s ? R_IDLE : R_DATA;
                    end
                end
                R_DATA: begin
                    if (tmr1_q == 16'(BAUD_DIV - 1)) begin
                        tmr1_q <= '0;
                        cnt1_q <= cnt1_q + 4'h1;
                        if (cnt1_q == len1 - 4'h1) begin
                            st1_q <= R_STOP;
                            sh1_q <= rx1_word;
                        end else begin
                            sh1_q <= shift_in(sh1_q, cfg1.msb_first, rx_s);
                        end
                    end
                end
                R_STOP: begin
                    if (done1) begin
                        st1_q <= R_IDLE;
                    end
                end
            endcase
        end
    end

    // Buffers; a finished receive wins over a CPU write in the same cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            buf0_q <= `SCSB_BUF_RST;
        end else if (!en) begin
            buf0_q <= `SCSB_BUF_RST;
        end else if (done0) begin
            buf0_q <= rx_align(sh0_nx, cfg0.msb_first, len0);
        end else if (wr0) begin
            buf0_q <= fit(cpu_req.wdata, len0);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            buf1_q <= `SCSB_BUF_RST;
        end else if (!en) begin
            buf1_q <= `SCSB_BUF_RST;
        end else if (done1) begin
            buf1_q <= sh1_q;
        end else if (wr1) begin
            buf1_q <= fit(cpu_req.wdata, len1);
        end
    end

    // Reads see only the buffers, never a shift register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (cpu_req.rd) begin
            unique case (cpu_req.addr)
                `SCSB_ADDR_CH0: rdata_q <= buf0_q;
                `SCSB_ADDR_CH1: rdata_q <= buf1_q;
                default:        rdata_q <= '0;
            endcase
        end
    end

    assign cpu_rdata               = rdata_q;
    assign three_wire_clock_pin_o  = sck_q;
    assign three_wire_clock_pin_oe = en && cfg0.run && cfg0.three_wire && cfg0.master;
    assign three_wire_data_out_pin = so0_q;
    assign async_transmit_pin      = txd_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_rx_bit;
        st1_q == R_DATA && tmr1_q == 16'(BAUD_DIV - 1) && cnt1_q != len1 - 4'h1;
    endsequence

    sequence s_tx_load;
        f_pop && !cfg0.three_wire;
    endsequence

    buf_hold_reset_a: assert property (!en |=> buf0_q == 8'h00 && buf1_q == 8'h00)
        else $error("buffers not cleared while clock supply off");
    wr_ignored_a: assert property (cpu_req.wr && !en && !done0 |=> buf0_q == 8'h00)
        else $error("write accepted while clock supply off");
    rx_copy_a: assert property (done1 |=> buf1_q == $past(sh1_q))
        else $error("received word not copied to buffer");
    seven_bit_a: assert property (done1 && len1 == `SCSB_LEN7 |=> buf1_q[7] == 1'b0)
        else $error("bit 7 set after 7-bit receive");
    read_decode_a: assert property (cpu_req.rd && cpu_req.addr == `SCSB_ADDR_CH1 |=> cpu_rdata == $past(buf1_q))
        else $error("channel 1 read returned wrong data");
    tx_load_a: assert property (f_pop |=> sh0_q == $past(f_data))
        else $error("written byte did not reach shift register");
    start_bit_a: assert property (s_tx_load ##1 (st0_q == T_START) |-> !async_transmit_pin)
        else $error("async start bit not low");
    rx_shift_a: assert property (s_rx_bit |=> (cfg1.msb_first ? sh1_q[0] : sh1_q[7]) == $past(rx_s))
        else $error("received bit not shifted in");
    pin_mode_a: assert property (cfg0.three_wire |-> async_transmit_pin)
        else $error("async pin driven in 3-wire mode");
    sck_dir_a: assert property (three_wire_clock_pin_oe |-> cfg0.master && cfg0.three_wire)
        else $error("serial clock driven in slave mode");
    sck_idle_a: assert property (st0_q == T_IDLE |-> three_wire_clock_pin_o)
        else $error("serial clock not high between frames");
endmodule

/* File: test/scsb_peer.sv */
// Purpose: Far-side serial peer (async line partner and 3-wire clock master or slave)
// Assumes: Bit time 64 ns; called through hierarchical tasks
// Notes:   Clock stands high between frames; data line inverts once released
`timescale 1ns/1ps
module scsb_peer (
    // Async side
    output logic      rxd,
    input  wire logic txd,
    // 3-wire side
    input  wire logic sck_in,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        rxd = 1'b1;
        sck = 1'b1;
        sdi = 1'b0;
    end
    // Frame into the receive-only channel
    task automatic send_async(input logic [7:0] b, input int len, input logic msb);
        rxd = 1'b0;
        #64;
        for (int i = 0; i < len; i++) begin
            rxd = msb ? b[len-1-i] : b[i];
            #64;
        end
        rxd = 1'b1;
        #64;
    endtask
    // Listener on the transmit-only channel
    task automatic recv_async(input int len, input logic msb, output logic [7:0] b, output logic ok);
        int n;
        b = 8'h00;
        ok = 1'b0;
        n = 0;
        while (txd !== 1'b0 && n < 40000) begin
            #1;
            n++;
        end
        if (n < 40000) begin
            ok = 1'b1;
            #32;
            for (int i = 0; i < len; i++) begin
                #64;
                if (msb) b[len-1-i] = txd;
                else b[i] = txd;
            end
            #64;
        end
    endtask
    // Drive on falling edge, sample on rising edge
    task automatic xfer3(input logic [7:0] tx, input int len, input logic msb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < len; i++) begin
            sck = 1'b0;
            sdi = msb ? tx[len-1-i] : tx[i];
            #32;
            sck = 1'b1;
            if (msb) rx[len-1-i] = sdo;
            else rx[i] = sdo;
            #32;
        end
        sdi = ~sdi;
    endtask
    // Slave to the block's clock: drive after each fall, sample at each rise
    task automatic xfer3_slave(input logic [7:0] tx, output logic [7:0] rx, output logic ok);
        int   n;
        int   i;
        logic prev;
        rx = 8'h00;
        n = 0;
        i = 0;
        prev = sck_in;
        while (i < 8 && n < 4000) begin
            #1;
            n++;
            if (prev && !sck_in) sdi = tx[7-i];
            if (!prev && sck_in) begin
                rx[7-i] = sdo;
                i++;
            end
            prev = sck_in;
        end
        sdi = ~sdi;
        ok = (i == 8);
    endtask
endmodule

/* File: test/tb_scsb_top.sv */
// Purpose: Self-checking bench of the serial channel shift buffer
// Assumes: Default counts; inputs change 1 ns after the rising edge
// Notes:   3-wire runs once as slave and once as clock master
`timescale 1ns/1ps
`include "scsb_defs.svh"
module tb_scsb_top;
    import scsb_pkg::*;
    logic          clk_sys;
    logic          nrst;
    logic          en;
    logic          sck_p;
    logic          sdi;
    logic          rxd;
    logic          sck_o;
    logic          sck_oe;
    logic          sdo;
    logic          txd;
    logic          tx_space;
    logic          ok;
    wire logic     sck_w;
    scsb_cpu_req_t req;
    scsb_ch_cfg_t  cfg0;
    scsb_ch_cfg_t  cfg1;
    logic [7:0]    rdata;
    logic [7:0]    got;
    logic [7:0]    exp;
    int            len;
    int            n_fail;
    int            n_tests;
    assign sck_w = sck_oe ? sck_o : sck_p;
    scsb_top dut_u (
        .clk_sys(clk_sys), .nrst(nrst), .cpu_req(req), .cpu_rdata(rdata), .tx_space(tx_space),
        .serial_unit_clock_enable(en), .cfg0(cfg0), .cfg1(cfg1),
        .three_wire_clock_pin_i(sck_w), .three_wire_clock_pin_o(sck_o), .three_wire_clock_pin_oe(sck_oe),
        .three_wire_data_in_pin(sdi), .three_wire_data_out_pin(sdo),
        .async_receive_pin(rxd), .async_transmit_pin(txd)
    );
    scsb_peer peer_u (.rxd(rxd), .txd(txd), .sck_in(sck_w), .sck(sck_p), .sdi(sdi), .sdo(sdo));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    function automatic scsb_ch_cfg_t mk(input logic r, input logic l8, input logic msb, input logic tw,
                                        input logic ms);
        scsb_ch_cfg_t c;
        c.run = r;
        c.op_low = {7'h00, l8};
        c.msb_first = msb;
        c.three_wire = tw;
        c.master = ms;
        return c;
    endfunction
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge clk_sys);
        #1;
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        req.rd = 1'b1;
        req.addr = a;
        @(posedge clk_sys);
        #1;
        req.rd = 1'b0;
        d = rdata;
    endtask
    // Receive lands by the end of the frame; poll with a bound
    task automatic rd_wait(input string nm, input logic [19:0] a, input logic [7:0] e);
        for (int i = 0; i < 20; i++) begin
            rd(a, got);
            if (got === e) break;
        end
        chk8(nm, e, got);
    endtask
    task automatic wait_space(input logic e);
        int n;
        n = 0;
        while (tx_space !== e && n < 4000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 4000) begin
            n_fail++;
            $display("Error tx_space wait expected %b seen %b", e, tx_space);
            end_of_test();
        end
    endtask
    initial begin
        nrst = 1'b0;
        en = 1'b1;
        req = '0;
        n_fail = 0;
        n_tests = 0;
        cfg0 = mk(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        cfg1 = mk(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        repeat (10) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        rd(`SCSB_ADDR_CH0, got);
        chk8("buf0 reset", 8'h00, got);
        rd(`SCSB_ADDR_CH1, got);
        chk8("buf1 reset", 8'h00, got);
        rd(20'hFFF14, got);
        chk8("unmapped read", 8'h00, got);
        chk1("tx_space reset", 1'b1, tx_space);
        wr(`SCSB_ADDR_CH0, 8'hA5);
        rd(`SCSB_ADDR_CH0, got);
        chk8("write while stopped", 8'h00, got);
        cfg0 = mk(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        cfg1 = mk(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        en = 1'b0;
        wr(`SCSB_ADDR_CH0, 8'h5A);
        #1;
        en = 1'b1;
        rd(`SCSB_ADDR_CH0, got);
        chk8("write with unit off", 8'h00, got);
        // Async transmit and receive in both word lengths and both bit orders
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            #1;
            cfg0 = mk(1'b1, m[0], m[1], 1'b0, 1'b0);
            cfg1 = mk(1'b1, m[0], m[1], 1'b0, 1'b0);
            len = m[0] ? 8 : 7;
            exp = m[0] ? 8'hD3 : 8'h53;
            fork
                peer_u.recv_async(len, m[1], got, ok);
                wr(`SCSB_ADDR_CH0, 8'hD3);
            join
            chk1("async frame seen", 1'b1, ok);
            chk8("async tx word", exp, got);
            rd(`SCSB_ADDR_CH0, got);
            chk8("tx buffer read", exp, got);
            peer_u.send_async(8'hC5, len, m[1]);
            rd_wait("async rx word", `SCSB_ADDR_CH1, m[0] ? 8'hC5 : 8'h45);
        end
        cfg0 = mk(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 17; i++) begin
            wr(`SCSB_ADDR_CH0, 8'(i));
        end
        chk1("fifo full", 1'b0, tx_space);
        wr(`SCSB_ADDR_CH0, 8'h77);
        rd(`SCSB_ADDR_CH0, got);
        chk8("buffer when full", 8'h77, got);
        wait_space(1'b1);
        en = 1'b0;
        @(posedge clk_sys);
        #1;
        chk1("flush space", 1'b1, tx_space);
        rd(`SCSB_ADDR_CH0, got);
        chk8("buf0 unit off", 8'h00, got);
        en = 1'b1;
        cfg0 = mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        repeat (40) @(posedge clk_sys);
        #1;
        chk1("slave clock oe", 1'b0, sck_oe);
        wr(`SCSB_ADDR_CH0, 8'h96);
        repeat (4) @(posedge clk_sys);
        #1;
        peer_u.xfer3(8'h4B, 8, 1'b1, got);
        chk8("3-wire out", 8'h96, got);
        rd_wait("3-wire in", `SCSB_ADDR_CH0, 8'h4B);
        @(posedge clk_sys);
        #1;
        cfg0 = mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        #1;
        chk1("master clock oe", 1'b1, sck_oe);
        wr(`SCSB_ADDR_CH0, 8'h3C);
        peer_u.xfer3_slave(8'hA6, got, ok);
        chk1("master frame done", 1'b1, ok);
        chk8("master out", 8'h3C, got);
        rd_wait("master in", `SCSB_ADDR_CH0, 8'hA6);
        chk1("master clock idle", 1'b1, sck_w);
        end_of_test();
    end
endmodule
